// *** fcp_consts.vh ***
/*
  Constants of the flash command and protect controller.
  Assumes inclusion by bare name from the design files.
*/
`ifndef FCP_CONSTS_VH
`define FCP_CONSTS_VH
`define FCP_ADDR_COMMAND   12'hFF8
`define FCP_ADDR_PAGE      12'hFF9
`define FCP_CMD_RESET      8'h00
`define FCP_CMD_UNLOCK1    8'h73
`define FCP_CMD_UNLOCK2    8'h8C
`define FCP_CMD_PAGE_ERASE 8'h95
`define FCP_CMD_MASS_ERASE 8'h63
`define FCP_CMD_LOCK_SEL   8'h5E
`define FCP_ST_LOCKED      6'h00
`define FCP_ST_FIRST       6'h01
`define FCP_ST_SECOND      6'h02
`define FCP_ST_UNLOCKED    6'h03
`define FCP_ST_LOCK_SEL    6'h04
`define FCP_ST_PROGRAM     6'h08
`define FCP_ST_ERASE       6'h10
`define FCP_PAGE_RESET     8'h00
`define FCP_LOCK_RESET     8'h00
`define FCP_PAGE_MSB       6
`define FCP_INFO_BIT       7
`define FCP_ERASED_BYTE    8'hFF
`define FCP_INFO_BASE      16'hFE00
`endif

// *** fcp_sector_map.v ***
/*
  Maps a page number onto its sector lock bit and tells whether it is locked.
  Assumes the sector size is fixed when the design is built.
*/
`timescale 1ns/10ps
`default_nettype none
module fcp_sector_map
#(
  parameter PAGES_PER_SECTOR_LOG2 = 4
)
(
  input  wire [6:0] page,
  input  wire [7:0] sector_lockout,
  output wire       locked
);
  wire [6:0] sector_full;
  assign sector_full = page >> PAGES_PER_SECTOR_LOG2;
  // The sector range per bit is a build-time choice.
  assign locked = (sector_full > 7'h07) ? 1'b0 : sector_lockout[sector_full[2:0]]; // [R26]
endmodule
`default_nettype wire

// *** fcp_ctrl.v ***
/*
  Command decoder, status, page select and sector lockout of the flash controller.
  Assumes single-cycle register file strobes and a flash array that reports done.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fcp_consts.vh"
// Functional notes
// [R1] Bypass mode hands raw flash control signals to the general-purpose pins.
// [R2] Debugger access disregards the write-protect option.
// [R3] Debugger access ignores sector lockout for program and erase.
// [R4] Debugger byte programs are accepted at any address.
// [R5] Debugger may write lockout bits to one or zero.
// [R6] Debugger unlocks without rewriting the page after two codes.
// [R7] Debugger page writes while unlocked update the page.
// [R8] Mass erase works only under debugger access.
// [R9] Command is write-only, status read-only, at one address.
// [R10] Two unlock codes in order advance the unlock state.
// [R11] Page erase code while unlocked erases the selected page.
// [R12] Lockout select code redirects the shared address to lockout.
// [R13] Unknown or out-of-order codes return to locked.
// [R14] Status is always readable and encodes the unlock states.
// [R15] Program reads 00_1xxx, erase 01_0xxx, top two bits zero.
// [R16] A page is 512 bytes, erased to all ones.
// [R17] Page field supplies flash address bits 15 to 9.
// [R18] Info enable maps info area at FE00H to FFFFH.
// [R19] Page register hidden while lockout is selected.
// [R20] Lockout reachable only after its select code.
// [R21] User writes to lockout only set bits; reads return them.
// [R22] Locked sectors reject user program and erase; clear at reset.
// [R23] User code resets, writes page, two codes, rewrites page.
// [R24] User unlocked programming only inside the unlocked page.
// [R25] Page erase completion relocks; the processor stalls meanwhile.
// [R26] Sector to page range mapping is a build-time parameter.
module fcp_ctrl
#(
  parameter PAGES_PER_SECTOR_LOG2 = 4
)
(
  input  wire        mclk,
  input  wire        rst_b,
  input  wire [11:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        debug_access,
  input  wire        write_protect_opt,
  input  wire        bypass_mode,
  input  wire [15:0] mem_addr,
  input  wire [7:0]  mem_wdata,
  input  wire        mem_wr,
  output reg         flash_program,
  output reg         flash_page_erase,
  output reg         flash_mass_erase,
  output reg  [15:0] flash_addr,
  output reg  [7:0]  flash_wdata,
  output wire [7:0]  flash_erase_value,
  output wire        flash_info_sel,
  input  wire        flash_done,
  output wire        cpu_stall,
  input  wire        gpio_prog_in,
  input  wire        gpio_erase_in,
  input  wire [15:0] gpio_addr_in,
  input  wire [7:0]  gpio_data_in,
  output wire        raw_program,
  output wire        raw_erase,
  output wire [15:0] raw_addr,
  output wire [7:0]  raw_wdata
);
  localparam S_LOCKED   = 3'd0;
  localparam S_FIRST    = 3'd1;
  localparam S_SECOND   = 3'd2;
  localparam S_UNLOCKED = 3'd3;
  localparam S_LOCK_SEL = 3'd4;
  localparam S_PROGRAM  = 3'd5;
  localparam S_ERASE    = 3'd6;
  localparam S_PAGEWAIT = 3'd7;

  reg        rst_s1;
  reg        rst_s2;
  reg        dbg_s1;
  reg        dbg_s2;
  reg        wp_s1;
  reg        wp_s2;
  reg        byp_s1;
  reg        byp_s2;
  reg        gp_prog_s1;
  reg        gp_prog_s2;
  reg        gp_erase_s1;
  reg        gp_erase_s2;
  reg [15:0] gp_addr_s1;
  reg [15:0] gp_addr_s2;
  reg [7:0]  gp_data_s1;
  reg [7:0]  gp_data_s2;
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [7:0]  page_selection;
  reg [7:0]  sector_lockout;
  reg        erase_is_mass;
  wire       wr_cmd;
  wire       wr_page;
  wire       page_locked;
  wire       addr_locked;
  wire       user_block;
  wire       in_page;
  wire       busy;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  always @(posedge mclk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      dbg_s1      <= 1'b0;
      dbg_s2      <= 1'b0;
      wp_s1       <= 1'b0;
      wp_s2       <= 1'b0;
      byp_s1      <= 1'b0;
      byp_s2      <= 1'b0;
      gp_prog_s1  <= 1'b0;
      gp_prog_s2  <= 1'b0;
      gp_erase_s1 <= 1'b0;
      gp_erase_s2 <= 1'b0;
      gp_addr_s1  <= 16'h0000;
      gp_addr_s2  <= 16'h0000;
      gp_data_s1  <= 8'h00;
      gp_data_s2  <= 8'h00;
    end
    else
    begin
      dbg_s1      <= debug_access;
      dbg_s2      <= dbg_s1;
      wp_s1       <= write_protect_opt;
      wp_s2       <= wp_s1;
      byp_s1      <= bypass_mode;
      byp_s2      <= byp_s1;
      gp_prog_s1  <= gpio_prog_in;
      gp_prog_s2  <= gp_prog_s1;
      gp_erase_s1 <= gpio_erase_in;
      gp_erase_s2 <= gp_erase_s1;
      gp_addr_s1  <= gpio_addr_in;
      gp_addr_s2  <= gp_addr_s1;
      gp_data_s1  <= gpio_data_in;
      gp_data_s2  <= gp_data_s1;
    end
  end

  assign wr_cmd  = reg_wr && (reg_addr == `FCP_ADDR_COMMAND); // [R9]
  assign wr_page = reg_wr && (reg_addr == `FCP_ADDR_PAGE);

  fcp_sector_map #(.PAGES_PER_SECTOR_LOG2(PAGES_PER_SECTOR_LOG2)) u_page_map
  (
    .page           (page_selection[`FCP_PAGE_MSB:0]),
    .sector_lockout (sector_lockout),
    .locked         (page_locked)
  );

  fcp_sector_map #(.PAGES_PER_SECTOR_LOG2(PAGES_PER_SECTOR_LOG2)) u_addr_map
  (
    .page           (mem_addr[15:9]),
    .sector_lockout (sector_lockout),
    .locked         (addr_locked)
  );

  // User code is blocked by the option bit; the debugger is not.
  assign user_block = !dbg_s2 && wp_s2; // [R2]
  assign in_page    = (mem_addr[15:9] == page_selection[`FCP_PAGE_MSB:0]); // [R17] [R24]
  assign busy       = (state == S_PROGRAM) || (state == S_ERASE);
  assign cpu_stall  = busy && !byp_s2; // [R25]

  always @*
  begin
    next_state = state;
    case (state)
      S_LOCKED:
        if (wr_cmd)
          next_state = (reg_wdata == `FCP_CMD_UNLOCK1) ? S_FIRST :
                       (reg_wdata == `FCP_CMD_LOCK_SEL) ? S_LOCK_SEL : S_LOCKED; // [R10] [R12]
      S_FIRST:
        if (wr_cmd)
          next_state = (reg_wdata == `FCP_CMD_UNLOCK2) ?
                       (dbg_s2 ? S_UNLOCKED : S_PAGEWAIT) : S_LOCKED; // [R10] [R6] [R13]
        else if (wr_page)
          next_state = S_LOCKED; // [R13]
      S_PAGEWAIT:
        if (wr_cmd)
          next_state = S_LOCKED; // [R13]
        else if (wr_page)
          next_state = (reg_wdata == page_selection) ? S_UNLOCKED : S_LOCKED; // [R23]
      S_SECOND:
        next_state = S_LOCKED;
      S_UNLOCKED:
        if (wr_cmd)
        begin
          if (reg_wdata == `FCP_CMD_PAGE_ERASE && !user_block && (dbg_s2 || !page_locked))
            next_state = S_ERASE; // [R11] [R22] [R3]
          else if (reg_wdata == `FCP_CMD_MASS_ERASE && dbg_s2)
            next_state = S_ERASE; // [R8]
          else if (reg_wdata == `FCP_CMD_LOCK_SEL)
            next_state = S_LOCK_SEL; // [R12]
          else
            next_state = S_LOCKED; // [R13]
        end
        else if (wr_page && !dbg_s2)
          next_state = S_LOCKED; // [R13]
        else if (mem_wr && !user_block && (dbg_s2 || (in_page && !addr_locked)))
          next_state = S_PROGRAM; // [R4] [R24] [R22] [R3]
      S_LOCK_SEL:
        if (wr_cmd)
          next_state = (reg_wdata == `FCP_CMD_LOCK_SEL) ? S_LOCK_SEL : S_LOCKED; // [R12]
      S_PROGRAM:
        if (flash_done)
          next_state = S_UNLOCKED;
      S_ERASE:
        if (flash_done)
          next_state = S_LOCKED; // [R25]
      default:
        next_state = S_LOCKED;
    endcase
    if (byp_s2)
      next_state = S_LOCKED; // [R1]
  end

  always @(posedge mclk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      state            <= S_LOCKED;
      page_selection   <= `FCP_PAGE_RESET;
      sector_lockout   <= `FCP_LOCK_RESET; // [R22]
      erase_is_mass    <= 1'b0;
      flash_program    <= 1'b0;
      flash_page_erase <= 1'b0;
      flash_mass_erase <= 1'b0;
      flash_addr       <= 16'h0000;
      flash_wdata      <= 8'h00;
      reg_rdata        <= 8'h00;
    end
    else
    begin
      state            <= next_state;
      flash_program    <= 1'b0;
      flash_page_erase <= 1'b0;
      flash_mass_erase <= 1'b0;
      if (wr_page && state == S_LOCK_SEL) // [R20]
        sector_lockout <= dbg_s2 ? reg_wdata : (sector_lockout | reg_wdata); // [R5] [R21]
      else if (wr_page && !busy && (state != S_UNLOCKED || dbg_s2)) // [R19] [R7]
        page_selection <= reg_wdata;
      if (state == S_UNLOCKED && next_state == S_PROGRAM)
      begin
        flash_program <= 1'b1;
        flash_addr    <= mem_addr;
        flash_wdata   <= mem_wdata;
      end
      if (state == S_UNLOCKED && next_state == S_ERASE)
      begin
        erase_is_mass    <= (reg_wdata == `FCP_CMD_MASS_ERASE);
        flash_mass_erase <= (reg_wdata == `FCP_CMD_MASS_ERASE); // [R8]
        flash_page_erase <= (reg_wdata != `FCP_CMD_MASS_ERASE); // [R11]
        flash_addr       <= {page_selection[`FCP_PAGE_MSB:0], 9'h000}; // [R16] [R17]
      end
      if (reg_rd && reg_addr == `FCP_ADDR_COMMAND)
        reg_rdata <= {2'b00, status_code(state)}; // [R14] [R15]
      else if (reg_rd && reg_addr == `FCP_ADDR_PAGE)
        reg_rdata <= (state == S_LOCK_SEL) ? sector_lockout : page_selection; // [R19] [R21]
    end
  end

  function [5:0] status_code;
    input [2:0] st;
    begin
      case (st)
        S_LOCKED:   status_code = `FCP_ST_LOCKED;
        S_FIRST:    status_code = `FCP_ST_FIRST;
        S_PAGEWAIT: status_code = `FCP_ST_SECOND;
        S_SECOND:   status_code = `FCP_ST_SECOND;
        S_UNLOCKED: status_code = `FCP_ST_UNLOCKED;
        S_LOCK_SEL: status_code = `FCP_ST_LOCK_SEL;
        S_PROGRAM:  status_code = `FCP_ST_PROGRAM;
        S_ERASE:    status_code = `FCP_ST_ERASE;
        default:    status_code = `FCP_ST_LOCKED;
      endcase
    end
  endfunction

  assign flash_erase_value = `FCP_ERASED_BYTE; // [R16]
  // Info area overlays FE00H and up when enabled.
  assign flash_info_sel = page_selection[`FCP_INFO_BIT] && (flash_addr >= `FCP_INFO_BASE); // [R18]
  assign raw_program = byp_s2 & gp_prog_s2; // [R1]
  assign raw_erase   = byp_s2 & gp_erase_s2;
  assign raw_addr    = byp_s2 ? gp_addr_s2 : 16'h0000;
  assign raw_wdata   = byp_s2 ? gp_data_s2 : 8'h00;
endmodule
`default_nettype wire

// *** fcp_ctrl_monitor.sv ***
/* Port checker of the flash command and protect controller.
   Assumes the bind after the module and a flash array that never answers at once. */
`timescale 1ns/10ps
`default_nettype none
module fcp_ctrl_monitor
(
  input wire        mclk,
  input wire        rst_b,
  input wire [11:0] reg_addr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        debug_access,
  input wire        write_protect_opt,
  input wire        bypass_mode,
  input wire        flash_program,
  input wire        flash_page_erase,
  input wire        flash_mass_erase,
  input wire [15:0] flash_addr,
  input wire [7:0]  flash_erase_value,
  input wire        flash_info_sel,
  input wire        flash_done,
  input wire        cpu_stall,
  input wire        raw_program,
  input wire        raw_erase
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_erase_value: assert property (flash_erase_value == 8'hFF) else $error("erase value");
  a_status_top:
    assert property (reg_rd && reg_addr == 12'hFF8 |=> reg_rdata[7:6] == 2'b00) else $error("top");
  a_info_window:
    assert property (flash_info_sel |-> flash_addr >= 16'hFE00) else $error("info");
  a_erase_aligned:
    assert property (flash_page_erase |-> flash_addr[8:0] == 9'h000) else $error("erase addr");
  a_erase_stall:
    assert property (flash_page_erase |-> cpu_stall ##1 !flash_page_erase) else $error("stall");
  a_stall_release:
    assert property (cpu_stall && flash_done |=> !cpu_stall) else $error("rel");
  a_mass_debug: assert property (flash_mass_erase |-> debug_access) else $error("mass");
  a_protect_user:
    assert property (flash_program |-> debug_access || !write_protect_opt) else $error("wp");
  a_bypass_quiet:
    assert property (!bypass_mode [*4] |-> !raw_program && !raw_erase) else $error("raw");
endmodule
bind fcp_ctrl fcp_ctrl_monitor mon_u (.mclk, .rst_b, .reg_addr, .reg_rd, .reg_rdata, .debug_access,
  .write_protect_opt, .bypass_mode, .flash_program, .flash_page_erase, .flash_mass_erase,
  .flash_addr, .flash_erase_value, .flash_info_sel, .flash_done, .cpu_stall, .raw_program,
  .raw_erase);
`default_nettype wire

// *** fcp_flash_model.sv ***
/* Flash array model that answers each started operation after a fixed time.
   Assumes start is a one-cycle pulse. */
`timescale 1ns/10ps
`default_nettype none
module fcp_flash_model
#(
  parameter LAT = 12
)
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic start,
  output var  logic done
);
  integer cnt;
  always @(posedge mclk or negedge rst_b)
  begin
    done <= 1'b0;
    if (!rst_b)
      cnt <= 0;
    else if (start)
      cnt <= LAT;
    else if (cnt > 0)
    begin
      cnt  <= cnt - 1;
      done <= (cnt == 1);
    end
  end
endmodule
`default_nettype wire

// *** flash_command_and_protect_ctrl_bench.sv ***
/* Self-checking bench of the flash command and protect controller.
   Assumes sixteen pages for each lockout bit. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, v) begin samples_checked++; if ((v) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module flash_command_and_protect_ctrl_bench;
  logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, mem_wr = 0, debug_access = 0;
  logic write_protect_opt = 0, bypass_mode = 0, gpio_prog_in = 0, gpio_erase_in = 0;
  logic [11:0] reg_addr = 0;
  logic [7:0]  reg_wdata = 0, mem_wdata = 0, gpio_data_in = 0, reg_rdata, flash_wdata;
  logic [7:0]  flash_erase_value, raw_wdata;
  logic [15:0] mem_addr = 0, gpio_addr_in = 0, flash_addr, raw_addr, last_addr, erase_addr;
  logic        flash_program, flash_page_erase, flash_mass_erase, flash_info_sel;
  logic        flash_done, cpu_stall, raw_program, raw_erase;
  logic [7:0]  last_data;
  logic        last_info;
  int          fails = 0, samples_checked = 0, cyc = 0, n_prog = 0, n_erase = 0, n_mass = 0;
  fcp_ctrl dut_u (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .debug_access, .write_protect_opt, .bypass_mode, .mem_addr, .mem_wdata, .mem_wr,
    .flash_program, .flash_page_erase, .flash_mass_erase, .flash_addr, .flash_wdata,
    .flash_erase_value, .flash_info_sel, .flash_done, .cpu_stall, .gpio_prog_in,
    .gpio_erase_in, .gpio_addr_in, .gpio_data_in, .raw_program, .raw_erase, .raw_addr,
    .raw_wdata);
  fcp_flash_model flash_u (.mclk, .rst_b, .done(flash_done),
    .start(flash_program | flash_page_erase | flash_mass_erase));
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (flash_program)
    begin
      n_prog++;
      last_addr = flash_addr;
      last_data = flash_wdata;
      last_info = flash_info_sel;
    end
    if (flash_page_erase)
    begin
      n_erase++;
      erase_addr = flash_addr;
    end
    if (flash_mass_erase)
      n_mass++;
    if (cyc == 5000)
    begin
      fails++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic mw(input logic [15:0] a);
    @(posedge mclk);
    mem_wr <= 1'b1;
    mem_addr <= a;
    mem_wdata <= 8'h5A;
    @(posedge mclk);
    mem_wr <= 1'b0;
  endtask
  task automatic unlock(input logic [7:0] p);
    wr(12'hFF8, 8'h00);
    wr(12'hFF9, p);
    wr(12'hFF8, 8'h73);
    wr(12'hFF8, 8'h8C);
    wr(12'hFF9, p);
  endtask
  task automatic t_reset;
    rd(12'hFF8, 8'h00);
    rd(12'hFF9, 8'h00);
    wr(12'hFF8, 8'h5E);
    rd(12'hFF9, 8'h00);
  endtask
  task automatic t_user;
    wr(12'hFF8, 8'h00);
    wr(12'hFF9, 8'h05);
    wr(12'hFF8, 8'h73);
    rd(12'hFF8, 8'h01);
    wr(12'hFF8, 8'h8C);
    rd(12'hFF8, 8'h02);
    wr(12'hFF9, 8'h05);
    rd(12'hFF8, 8'h03);
    mw(16'h0000);
    mw(16'h0A12);
    rd(12'hFF8, 8'h08);
    repeat (20) @(posedge mclk);
    `CHK("program count", 1, n_prog)
    `CHK("program addr", 16'h0A12, last_addr)
    `CHK("program data", 8'h5A, last_data)
    `CHK("info sel", 1'b0, last_info)
    rd(12'hFF8, 8'h03);
    wr(12'hFF8, 8'h95);
    rd(12'hFF8, 8'h10);
    repeat (20) @(posedge mclk);
    `CHK("erase addr", 16'h0A00, erase_addr)
    rd(12'hFF8, 8'h00);
  endtask
  task automatic t_order;
    wr(12'hFF8, 8'h00);
    wr(12'hFF8, 8'h73);
    wr(12'hFF8, 8'h73);
    rd(12'hFF8, 8'h00);
    unlock(8'h05);
    wr(12'hFF8, 8'h63);
    rd(12'hFF8, 8'h00);
    `CHK("mass count", 0, n_mass)
  endtask
  task automatic t_lockout;
    wr(12'hFF8, 8'h00);
    wr(12'hFF8, 8'h5E);
    rd(12'hFF8, 8'h04);
    wr(12'hFF9, 8'h01);
    rd(12'hFF9, 8'h01);
    wr(12'hFF9, 8'h00);
    rd(12'hFF9, 8'h01);
    wr(12'hFF8, 8'h00);
    rd(12'hFF9, 8'h05);
    unlock(8'h03);
    mw(16'h0600);
    write_protect_opt <= 1'b1;
    unlock(8'h10);
    mw(16'h2000);
    repeat (20) @(posedge mclk);
    `CHK("program count", 1, n_prog)
  endtask
  task automatic t_debug;
    debug_access <= 1'b1;
    wr(12'hFF8, 8'h00);
    wr(12'hFF8, 8'h73);
    wr(12'hFF8, 8'h8C);
    rd(12'hFF8, 8'h03);
    mw(16'h0600);
    repeat (20) @(posedge mclk);
    `CHK("program addr", 16'h0600, last_addr)
    wr(12'hFF9, 8'hFF);
    mw(16'hFE10);
    repeat (20) @(posedge mclk);
    `CHK("info addr", 16'hFE10, last_addr)
    `CHK("info sel", 1'b1, last_info)
    wr(12'hFF9, 8'h07);
    wr(12'hFF8, 8'h95);
    repeat (20) @(posedge mclk);
    `CHK("erase addr", 16'h0E00, erase_addr)
    wr(12'hFF8, 8'h73);
    wr(12'hFF8, 8'h8C);
    wr(12'hFF8, 8'h63);
    repeat (20) @(posedge mclk);
    `CHK("mass count", 1, n_mass)
    wr(12'hFF8, 8'h00);
    wr(12'hFF8, 8'h5E);
    wr(12'hFF9, 8'h00);
    rd(12'hFF9, 8'h00);
    wr(12'hFF8, 8'h00);
    debug_access <= 1'b0;
  endtask
  task automatic t_bypass;
    gpio_addr_in <= 16'h1234;
    gpio_data_in <= 8'hC3;
    gpio_prog_in <= 1'b1;
    bypass_mode <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK("raw_addr", 16'h1234, raw_addr)
    `CHK("raw_wdata", 8'hC3, raw_wdata)
    `CHK("raw_program", 1'b1, raw_program)
    `CHK("raw_erase", 1'b0, raw_erase)
    wr(12'hFF8, 8'h73);
    rd(12'hFF8, 8'h00);
    bypass_mode <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK("raw_addr", 16'h0000, raw_addr)
    `CHK("raw_program", 1'b0, raw_program)
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    t_reset;
    t_user;
    t_order;
    t_lockout;
    t_debug;
    t_bypass;
    tally_and_finish;
  end
endmodule
`default_nettype wire
